// File: src/bias_az_pkg.sv
package bias_az_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 24;

  // register byte offsets
  localparam logic [7:0] PRIMARY_CFG_OFS  = 8'h00;
  localparam logic [7:0] TERTIARY_CFG_OFS = 8'h04;
  localparam logic [7:0] PAIR_SEL_OFS     = 8'h08;
  localparam logic [7:0] CONTROL_OFS      = 8'h0c;
  localparam logic [7:0] STATUS_OFS       = 8'h10;
  localparam logic [7:0] RESULT_OFS       = 8'h14;

  // field positions
  localparam int BURNOUT_LSB = 0;
  localparam int KIND_LSB    = 2;
  localparam int SWAP_BIT    = 0;
  localparam int START_BIT   = 0;
  localparam int STOP_BIT    = 1;

  // reset values
  localparam logic [1:0] BURNOUT_RST = 2'h0;
  localparam logic [1:0] KIND_RST    = 2'h0;
  localparam logic       SWAP_RST    = 1'h0;
  localparam logic [7:0] PAIR_RST    = 8'h01;

  // encodings
  localparam logic [1:0] KIND_CONTINUOUS = 2'h3;
  localparam logic [7:0] TEMP_PAIR       = 8'hde;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    burnout_off    = 2'b00,
    burnout_0p9_ua = 2'b01,
    burnout_3p7_ua = 2'b10,
    burnout_15_ua  = 2'b11
  } burnout_level_t;

  typedef enum logic [1:0] {
    seq_idle    = 2'b00,
    seq_normal  = 2'b01,
    seq_swapped = 2'b10
  } seq_state_t;

  // diode pair in either polarity counts as the temperature sensor
  function automatic logic is_temp_pair(input logic [7:0] pair);
    is_temp_pair = (pair == TEMP_PAIR) || (pair == {TEMP_PAIR[3:0], TEMP_PAIR[7:4]});
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == PRIMARY_CFG_OFS) || (addr == TERTIARY_CFG_OFS) ||
                (addr == PAIR_SEL_OFS) || (addr == CONTROL_OFS) ||
                (addr == STATUS_OFS) || (addr == RESULT_OFS);
  endfunction

endpackage

// File: src/offset_cancel_combine.sv
`timescale 1ns/1ps
`default_nettype none

module offset_cancel_combine (
  // codes of the two polarities
  input  wire logic [bias_az_pkg::CODE_W-1:0] normal_code,
  input  wire logic [bias_az_pkg::CODE_W-1:0] swapped_code,
  // averaged difference
  output logic      [bias_az_pkg::CODE_W-1:0] half_diff
);
  import bias_az_pkg::*;

  logic signed [CODE_W:0] diff;

  // one extra bit so the difference never wraps before the halving
  always_comb
  begin
    diff      = $signed({normal_code[CODE_W-1], normal_code}) -
                $signed({swapped_code[CODE_W-1], swapped_code});
    half_diff = diff[CODE_W:1];
  end

endmodule

`default_nettype wire

// File: src/input_bias_and_autozero_control.sv
`timescale 1ns/1ps
`default_nettype none

module input_bias_and_autozero_control (
  // clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // axi4-lite write address
  input  wire logic [bias_az_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                            awvalid,
  output var  logic                            awready,
  // axi4-lite write data
  input  wire logic [bias_az_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output var  logic                            wready,
  // axi4-lite write response
  output var  logic [1:0]                      bresp,
  output var  logic                            bvalid,
  input  wire logic                            bready,
  // axi4-lite read address
  input  wire logic [bias_az_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                            arvalid,
  output var  logic                            arready,
  // axi4-lite read data
  output var  logic [bias_az_pkg::DATA_W-1:0]  rdata,
  output var  logic [1:0]                      rresp,
  output var  logic                            rvalid,
  input  wire logic                            rready,
  // analog front end
  output var  bias_az_pkg::burnout_level_t     burnout_level,
  output var  logic                            diode_bias_enable,
  output var  logic [3:0]                      pos_input_sel,
  output var  logic [3:0]                      neg_input_sel,
  // modulator and decimation filter
  output var  logic                            convert_start,
  output var  logic                            convert_active,
  input  wire logic                            convert_done,
  input  wire logic [bias_az_pkg::CODE_W-1:0]  convert_data,
  // results
  output var  logic [bias_az_pkg::CODE_W-1:0]  result_data,
  output var  logic                            result_strobe
);
  import bias_az_pkg::*;

  logic [1:0]        burnout_sel_reg;
  logic [1:0]        kind_reg;
  logic              swap_en_reg;
  logic [7:0]        pair_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_held_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_held_reg;
  logic              result_valid_reg;
  logic [CODE_W-1:0] first_reg;
  seq_state_t        state_reg;
  logic [CODE_W-1:0] combined;
  logic [DATA_W-1:0] rd_word;
  logic              do_write;
  logic              low_lane;
  logic              start_req;
  logic              stop_req;
  logic              continuous;
  logic              result_take;

  assign do_write    = aw_held_reg && w_held_reg && !bvalid;
  assign low_lane    = do_write && w_strb_reg[0];
  assign start_req   = low_lane && (aw_addr_reg == CONTROL_OFS) && w_data_reg[START_BIT];
  assign stop_req    = low_lane && (aw_addr_reg == CONTROL_OFS) && w_data_reg[STOP_BIT];
  assign continuous  = (kind_reg == KIND_CONTINUOUS);
  assign result_take = arvalid && arready && (araddr == RESULT_OFS);

  offset_cancel_combine u_combine (
    .normal_code  (first_reg),
    .swapped_code (convert_data),
    .half_diff    (combined)
  );

  // write address; one write in flight, so ready waits for the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready     <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else
    begin
      awready <= awvalid && !awready && !aw_held_reg && !bvalid;
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
    end
  end

  // write data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready     <= 1'b0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else
    begin
      wready <= wvalid && !wready && !w_held_reg && !bvalid;
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // configuration fields; the burnout write needs no converter state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      burnout_sel_reg <= BURNOUT_RST;
      kind_reg        <= KIND_RST;
      swap_en_reg     <= SWAP_RST;
      pair_reg        <= PAIR_RST;
    end
    else if (low_lane)
    begin
      if (aw_addr_reg == PRIMARY_CFG_OFS)
      begin
        burnout_sel_reg <= w_data_reg[BURNOUT_LSB +: 2];
        kind_reg        <= w_data_reg[KIND_LSB +: 2];
      end
      else if (aw_addr_reg == TERTIARY_CFG_OFS)
        swap_en_reg <= w_data_reg[SWAP_BIT];
      else if (aw_addr_reg == PAIR_SEL_OFS)
        pair_reg <= w_data_reg[7:0];
    end
  end

  // current source control, independent of the sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      burnout_level     <= burnout_off;
      diode_bias_enable <= 1'b0;
    end
    else
    begin
      // same code drives the source on vin+ and the sink on vin
      burnout_level     <= is_temp_pair(pair_reg) ? burnout_off
                                                  : burnout_level_t'(burnout_sel_reg);
      diode_bias_enable <= is_temp_pair(pair_reg);
    end
  end

  // conversion sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg      <= seq_idle;
      convert_start  <= 1'b0;
      convert_active <= 1'b0;
      pos_input_sel  <= PAIR_RST[7:4];
      neg_input_sel  <= PAIR_RST[3:0];
      first_reg      <= '0;
      result_data    <= '0;
      result_strobe  <= 1'b0;
    end
    else
    begin
      convert_start <= 1'b0;
      result_strobe <= 1'b0;
      case (state_reg)
        seq_idle:
        begin
          pos_input_sel <= pair_reg[7:4];
          neg_input_sel <= pair_reg[3:0];
          if (start_req)
          begin
            state_reg      <= seq_normal;
            convert_start  <= 1'b1;
            convert_active <= 1'b1;
          end
        end
        seq_normal:
        begin
          if (stop_req)
          begin
            state_reg      <= seq_idle;
            convert_active <= 1'b0;
          end
          else if (convert_done && swap_en_reg)
          begin
            // second half of the pair, inputs exchanged
            // exchange what is driven now, so a pair write mid-conversion cannot split the pair
            first_reg     <= convert_data;
            state_reg     <= seq_swapped;
            convert_start <= 1'b1;
            pos_input_sel <= neg_input_sel;
            neg_input_sel <= pos_input_sel;
          end
          else if (convert_done)
          begin
            // plain path: free-running filter in continuous mode
            result_data   <= convert_data;
            result_strobe <= 1'b1;
            if (!continuous)
            begin
              state_reg      <= seq_idle;
              convert_active <= 1'b0;
            end
          end
        end
        seq_swapped:
        begin
          if (stop_req)
          begin
            state_reg      <= seq_idle;
            convert_active <= 1'b0;
          end
          else if (convert_done)
          begin
            result_data   <= combined;
            result_strobe <= 1'b1;
            pos_input_sel <= pair_reg[7:4];
            neg_input_sel <= pair_reg[3:0];
            if (continuous)
            begin
              // restart with a filter reset in the same cycle
              state_reg     <= seq_normal;
              convert_start <= 1'b1;
            end
            else
            begin
              state_reg      <= seq_idle;
              convert_active <= 1'b0;
            end
          end
        end
        default:
        begin
          state_reg      <= seq_idle;
          convert_active <= 1'b0;
        end
      endcase
    end
  end

  // result flag: a new result beats a read in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_valid_reg <= 1'b0;
    else if (result_strobe)
      result_valid_reg <= 1'b1;
    else if (result_take)
      result_valid_reg <= 1'b0;
  end

  // read decode
  always_comb
  begin
    rd_word = '0;
    if (araddr == PRIMARY_CFG_OFS)
      rd_word = {28'h0000000, kind_reg, burnout_sel_reg};
    else if (araddr == TERTIARY_CFG_OFS)
      rd_word = {31'h00000000, swap_en_reg};
    else if (araddr == PAIR_SEL_OFS)
      rd_word = {24'h000000, pair_reg};
    else if (araddr == STATUS_OFS)
      rd_word = {28'h0000000, diode_bias_enable, (state_reg == seq_swapped),
                 result_valid_reg, (state_reg != seq_idle)};
    else if (araddr == RESULT_OFS)
      rd_word = {{(DATA_W - CODE_W){result_data[CODE_W-1]}}, result_data};
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic signed [CODE_W:0] diff_chk;
  assign diff_chk = $signed({first_reg[CODE_W-1], first_reg}) -
                    $signed({convert_data[CODE_W-1], convert_data});

  sequence burnout_write_s;
    low_lane && (aw_addr_reg == PRIMARY_CFG_OFS) && !is_temp_pair(pair_reg);
  endsequence

  sequence normal_done_swap_s;
    state_reg == seq_normal && convert_done && swap_en_reg && !stop_req;
  endsequence

  sequence swapped_done_s;
    state_reg == seq_swapped && convert_done && !stop_req;
  endsequence

  a_burnout_write_applied: assert property (
    burnout_write_s |=> ##1 burnout_level == $past(w_data_reg[1:0], 2))
    else $error("burnout level not applied after write");

  a_burnout_held_idle: assert property (
    (state_reg == seq_idle && $stable(burnout_sel_reg) && $stable(pair_reg) &&
     burnout_sel_reg != BURNOUT_RST && !is_temp_pair(pair_reg))
    |-> burnout_level == burnout_level_t'(burnout_sel_reg))
    else $error("burnout level dropped while idle");

  a_diode_blocks_burnout: assert property (
    diode_bias_enable |-> burnout_level == burnout_off)
    else $error("burnout source on with diodes selected");

  a_diode_bias_select: assert property (
    diode_bias_enable == is_temp_pair($past(pair_reg)))
    else $error("diode bias does not track diode selection");

  a_no_swap_plain: assert property (
    (state_reg == seq_normal && !swap_en_reg) |=> state_reg != seq_swapped)
    else $error("swap phase entered with swapping off");

  a_swap_exchanges: assert property (
    normal_done_swap_s |=> convert_start && pos_input_sel == $past(neg_input_sel) &&
                            neg_input_sel == $past(pos_input_sel) && !result_strobe)
    else $error("swapped conversion did not exchange inputs");

  a_half_difference: assert property (
    swapped_done_s |=> result_strobe && result_data == $past(diff_chk[CODE_W:1]))
    else $error("result is not half the polarity difference");

  a_chain_no_gap: assert property (
    (swapped_done_s ##0 continuous) |=> convert_start && state_reg == seq_normal)
    else $error("continuous swap chain left a gap");

  a_single_shot_ends: assert property (
    (swapped_done_s ##0 !continuous) |=> state_reg == seq_idle && !convert_active)
    else $error("single shot did not end after swapped half");

endmodule

`default_nettype wire

// File: tb/input_bias_and_autozero_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module input_bias_and_autozero_control_tb;
  import bias_az_pkg::*;

  logic                aclk;
  logic                aresetn;
  logic [ADDR_W-1:0]   awaddr;
  logic                awvalid;
  logic                awready;
  logic [DATA_W-1:0]   wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [ADDR_W-1:0]   araddr;
  logic                arvalid;
  logic                arready;
  logic [DATA_W-1:0]   rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  burnout_level_t      burnout_level;
  logic                diode_bias_enable;
  logic [3:0]          pos_input_sel;
  logic [3:0]          neg_input_sel;
  logic                convert_start;
  logic                convert_active;
  logic                convert_done;
  logic [CODE_W-1:0]   convert_data;
  logic [CODE_W-1:0]   result_data;
  logic                result_strobe;
  int                  error_cnt;
  int                  checks_done;
  int                  starts;
  int                  strobes;
  int                  both;
  logic [3:0]          spos;
  logic [3:0]          sneg;
  logic [1:0]          resp;
  logic [31:0]         rd;

  input_bias_and_autozero_control u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .burnout_level(burnout_level), .diode_bias_enable(diode_bias_enable),
    .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
    .convert_start(convert_start), .convert_active(convert_active),
    .convert_done(convert_done), .convert_data(convert_data),
    .result_data(result_data), .result_strobe(result_strobe)
  );

  always #2 aclk = ~aclk;

  // pulses are counted here so no task can miss one while busy on the bus
  always @(posedge aclk)
  begin
    if (convert_start)
    begin
      starts <= starts + 1;
      spos   <= pos_input_sel;
      sneg   <= neg_input_sel;
    end
    if (result_strobe)
    begin
      strobes <= strobes + 1;
      if (convert_start)
        both <= both + 1;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    r = 2'h1;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_ok && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready)
      begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid)
      begin
        b_ok = 1;
        r = bresp;
      end
    end
    bready <= 1'b0;
    if (!b_ok)
      check(32'h0, 32'h1);
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_ok;
    logic r_ok;
    n = 0;
    ar_ok = 0;
    r_ok = 0;
    r = 2'h1;
    d = 32'hffffffff;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_ok && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (!ar_ok && arready)
      begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end
      if (rvalid)
      begin
        r_ok = 1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
    if (!r_ok)
      check(32'h0, 32'h2);
  endtask

  task automatic wait_for(ref int c, input int t);
    int n;
    n = 0;
    while (c < t && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    check(32'(c >= t), 32'h1);
  endtask

  task done_pulse(input logic [CODE_W-1:0] d);
    @(posedge aclk);
    convert_done <= 1'b1;
    convert_data <= d;
    @(posedge aclk);
    convert_done <= 1'b0;
    convert_data <= ~d;
  endtask

  task test_reset_and_map;
    axi_read(TERTIARY_CFG_OFS, rd, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    check(rd[0], SWAP_RST);
    check(burnout_level, BURNOUT_RST);
    axi_read(8'h20, rd, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    axi_write(8'h24, 32'h3, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask

  task test_burnout_levels;
    for (int i = 0; i < 4; i++)
    begin
      axi_write(PRIMARY_CFG_OFS, 32'(i), resp);
      repeat (2) @(posedge aclk);
      check(burnout_level, 32'(i));
      check({pos_input_sel, neg_input_sel}, {24'h0, PAIR_RST});
    end
  endtask

  task test_diode_pair;
    axi_write(PAIR_SEL_OFS, 32'(TEMP_PAIR), resp);
    repeat (2) @(posedge aclk);
    check(diode_bias_enable, 32'h1);
    check(burnout_level, 32'h0);
    check({pos_input_sel, neg_input_sel}, 32'hde);
    check(pos_input_sel, 32'hd);
    axi_read(PRIMARY_CFG_OFS, rd, resp);
    check(rd[1:0], 32'h3);
    axi_write(PAIR_SEL_OFS, 32'h23, resp);
    repeat (2) @(posedge aclk);
    check(diode_bias_enable, 32'h0);
    check(burnout_level, 32'h3);
  endtask

  task test_plain_single;
    int s0;
    int r0;
    s0 = starts;
    r0 = strobes;
    axi_write(TERTIARY_CFG_OFS, 32'h0, resp);
    axi_write(CONTROL_OFS, 32'h1, resp);
    wait_for(starts, s0 + 1);
    done_pulse(24'h123456);
    wait_for(strobes, r0 + 1);
    check(result_data, 32'h123456);
    check(starts, s0 + 1);
    check({spos, sneg}, 32'h23);
  endtask

  task test_swap_single;
    int s0;
    int r0;
    s0 = starts;
    r0 = strobes;
    axi_write(TERTIARY_CFG_OFS, 32'h1, resp);
    axi_write(CONTROL_OFS, 32'h1, resp);
    wait_for(starts, s0 + 1);
    check({spos, sneg}, 32'h23);
    // level change while converting must land at once
    axi_write(PRIMARY_CFG_OFS, 32'h2, resp);
    repeat (2) @(posedge aclk);
    check(burnout_level, 32'h2);
    check(convert_active, 32'h1);
    done_pulse(24'h000100);
    wait_for(starts, s0 + 2);
    check({spos, sneg}, 32'h32);
    check(strobes, r0);
    done_pulse(24'hfffe00);
    wait_for(strobes, r0 + 1);
    check(result_data, 32'h000180);
    check({pos_input_sel, neg_input_sel}, 32'h23);
    check(starts, s0 + 2);
    repeat (2) @(posedge aclk);
    check(convert_active, 32'h0);
  endtask

  task test_swap_continuous;
    int s0;
    int r0;
    int b0;
    s0 = starts;
    r0 = strobes;
    b0 = both;
    axi_write(PRIMARY_CFG_OFS, 32'h0c, resp);
    axi_write(CONTROL_OFS, 32'h1, resp);
    wait_for(starts, s0 + 1);
    done_pulse(24'h000003);
    wait_for(starts, s0 + 2);
    check({spos, sneg}, 32'h32);
    done_pulse(24'h000008);
    wait_for(strobes, r0 + 1);
    check(result_data, 32'hfffffd);
    check(both, b0 + 1);
    check(starts, s0 + 3);
    check({spos, sneg}, 32'h23);
    axi_write(CONTROL_OFS, 32'h2, resp);
    @(posedge aclk);
    check(convert_active, 32'h0);
  endtask

  // plain continuous: one start, the filter free-runs, every done is a result
  task test_plain_continuous;
    int s0;
    int r0;
    s0 = starts;
    r0 = strobes;
    axi_write(TERTIARY_CFG_OFS, 32'h0, resp);
    axi_write(PRIMARY_CFG_OFS, 32'h0c, resp);
    axi_write(CONTROL_OFS, 32'h1, resp);
    wait_for(starts, s0 + 1);
    done_pulse(24'h000011);
    wait_for(strobes, r0 + 1);
    done_pulse(24'hffff80);
    wait_for(strobes, r0 + 2);
    check(starts, s0 + 1);
    axi_read(STATUS_OFS, rd, resp);
    check(rd, 32'h3);
    axi_read(RESULT_OFS, rd, resp);
    check(rd, 32'hffffff80);
    axi_read(STATUS_OFS, rd, resp);
    check(rd, 32'h1);
    axi_write(CONTROL_OFS, 32'h2, resp);
    @(posedge aclk);
    check(convert_active, 32'h0);
  endtask

  task summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    aclk = 0;
    aresetn = 0;
    awaddr = 0;
    awvalid = 0;
    wdata = 0;
    wstrb = 0;
    wvalid = 0;
    bready = 0;
    araddr = 0;
    arvalid = 0;
    rready = 0;
    convert_done = 0;
    convert_data = 0;
    error_cnt = 0;
    checks_done = 0;
    starts = 0;
    strobes = 0;
    both = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_and_map();
    test_burnout_levels();
    test_diode_pair();
    test_plain_single();
    test_swap_single();
    test_swap_continuous();
    test_plain_continuous();
    summarize();
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
